// >>> common/ahr_pkg.sv
/*
 Constants, types and lane decoding shared by both ends of the converter
 readout link. Assumes a 50 MHz system clock on both ends.
*/
package ahr_pkg;
   // data shape
   localparam int NUM_CH = 8;
   localparam int CH_LOG = 3;
   localparam int DATA_W = 16;
   localparam int NUM_LANES = 8;
   localparam int BIT_CNT_W = 7;
   localparam int WORD_LSB = 4;
   localparam int CNT_W = 12;

   // serial lanes a..h onto data pin positions
   localparam int LANE_PIN [NUM_LANES] = '{7, 8, 9, 10, 3, 4, 5, 6};

   localparam logic [DATA_W-1:0] DATA_NONE = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ALL = 16'hFFFF;
   // idle pin levels {reset, start, rd_sclk, cs_n, wr_n, select}
   localparam logic [5:0] PIN_IDLE = 6'h0E;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int CONV_NS = 800;
   localparam int RST_PARTIAL_MIN_NS = 40;
   localparam int RST_FULL_MIN_NS = 3000;
   localparam int HOST_RST_PARTIAL_NS = 400;
   localparam int HOST_RST_FULL_NS = 4000;
   localparam int START_HIGH_NS = 80;
   localparam int LINK_HALF_NS = 160;
   localparam int BUSY_WAIT_NS = 400;

   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_PARTIAL_MIN_CYC =
      (RST_PARTIAL_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_FULL_MIN_CYC = (RST_FULL_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int HOST_RST_PARTIAL_CYC =
      (HOST_RST_PARTIAL_NS * CLK_MHZ + 999) / 1000;
   localparam int HOST_RST_FULL_CYC =
      (HOST_RST_FULL_NS * CLK_MHZ + 999) / 1000;
   localparam int START_HIGH_CYC = (START_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {AHR_LANES_2, AHR_LANES_4, AHR_LANES_8} ahr_lanes_e;
   typedef enum logic [2:0] {
      AHR_CMD_CONVERT, AHR_CMD_READ, AHR_CMD_WRITE,
      AHR_CMD_RESET_FULL, AHR_CMD_RESET_PARTIAL
   } ahr_cmd_e;

   // log2 of active serial lanes; extra lanes only in software mode
   function automatic logic [1:0] lanes_log(input logic sw,
                                            input ahr_lanes_e opt);
      logic [1:0] r;
      r = 2'h1;
      if (sw && opt == AHR_LANES_4) begin
         r = 2'h2;
      end else if (sw && opt == AHR_LANES_8) begin
         r = 2'h3;
      end
      return r;
   endfunction
endpackage

// >>> common/ahr_link_if.sv
/*
 Pin-level link between converter readout device and host controller.
 Data pins are resolved here from both enables; undriven bits read low,
 as the grounded low bits would in serial use.
*/
`timescale 1ns/10ps
interface ahr_link_if;
   logic reset;
   logic conversion_start;
   logic rd_sclk;
   logic cs_n;
   logic wr_n;
   logic interface_select;
   logic busy;
   logic first_channel_marker;
   logic [ahr_pkg::DATA_W-1:0] dev_data_out;
   logic [ahr_pkg::DATA_W-1:0] dev_data_oe;
   logic [ahr_pkg::DATA_W-1:0] host_data_out;
   logic [ahr_pkg::DATA_W-1:0] host_data_oe;
   logic [ahr_pkg::DATA_W-1:0] data_bus;

   // device wins where both drive
   assign data_bus = (dev_data_out & dev_data_oe) |
                     (host_data_out & host_data_oe & ~dev_data_oe);

   modport device (
      input reset, conversion_start, rd_sclk, cs_n, wr_n, interface_select,
      input data_bus,
      output busy, first_channel_marker, dev_data_out, dev_data_oe
   );
   modport host (
      output reset, conversion_start, rd_sclk, cs_n, wr_n, interface_select,
      output host_data_out, host_data_oe,
      input busy, first_channel_marker, data_bus
   );
endinterface

// >>> rtl/ahr_device.sv
/*
 Device end of the readout link: reset pulse classification, conversion
 busy, result capture, parallel and serial readout and parallel register
 writes. Assumes every link pin is asynchronous to i_clk and that the host
 keeps its link clock slow enough for two-stage sampling.
*/
//Overview of operation
//- reset input active high, held high resets
//- pulse length picks full or partial reset
//- host gives full reset after power up
//- shared pin is read strobe or serial clock
//- chip select low frames every transfer
//- busy rises with conversion start edge
//- busy falls once all channels converted
//- marker flags channel one being read
//- parallel pins drive only when selected, read
//- host grounds low data bits in serial
//- bits three to six carry lanes e-h
//- bit seven lane a, eight lane b
//- bit nine lane c only software wide
//- select low parallel, high serial
//- start edge samples all eight channels
//- software mode writes via write strobe
`timescale 1ns/10ps
module ahr_device (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // link to host
   ahr_link_if.device link,
   // converter results and mode straps
   input wire logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] i_channel_data,
   input wire logic i_software_mode,
   input wire ahr_pkg::ahr_lanes_e i_lane_opt,
   // register write and reset events
   output logic [ahr_pkg::DATA_W-1:0] o_reg_wr_data,
   output logic o_reg_wr_valid,
   output logic o_full_reset,
   output logic o_partial_reset
);
   localparam int SYNC_W = 6 + ahr_pkg::DATA_W;
   localparam int CW = ahr_pkg::CNT_W;
   localparam logic [SYNC_W-1:0] SYNC_IDLE =
      {ahr_pkg::PIN_IDLE, ahr_pkg::DATA_NONE};
   localparam logic [CW-1:0] FULL_MIN = CW'(ahr_pkg::RST_FULL_MIN_CYC);
   localparam logic [CW-1:0] PART_MIN = CW'(ahr_pkg::RST_PARTIAL_MIN_CYC);
   localparam logic [CW-1:0] CONV_LAST = CW'(ahr_pkg::CONV_CYC - 1);

   logic [SYNC_W-1:0] pin_vec;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   logic [4:0] prev_reg;
   logic rst_s, cnv_s, rd_s, cs_n_s, wr_n_s, sel_s;
   logic rst_p, cnv_p, rd_p, cs_n_p, wr_n_p;
   logic [ahr_pkg::DATA_W-1:0] data_s;

   logic [CW-1:0] rst_cnt_reg, rst_cnt_next;
   logic [CW-1:0] conv_cnt_reg, conv_cnt_next;
   logic busy_reg, busy_next;
   logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] sample_reg, sample_next;
   logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] result_reg, result_next;
   logic [ahr_pkg::CH_LOG-1:0] idx_reg, idx_next;
   logic [ahr_pkg::BIT_CNT_W-1:0] bit_reg, bit_next;
   logic [ahr_pkg::DATA_W-1:0] wr_data_reg, wr_data_next;
   logic wr_valid_reg, wr_valid_next;
   logic full_reg, full_next;
   logic part_reg, part_next;

   logic [ahr_pkg::DATA_W-1:0] out_reg, out_next;
   logic [ahr_pkg::DATA_W-1:0] oe_reg, oe_next;
   logic marker_reg, marker_next;

   // two-stage sampling of every link pin
   assign pin_vec = {link.reset, link.conversion_start, link.rd_sclk,
                     link.cs_n, link.wr_n, link.interface_select,
                     link.data_bus};
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta_reg <= SYNC_IDLE;
         sync_reg <= SYNC_IDLE;
         prev_reg <= SYNC_IDLE[SYNC_W-1:ahr_pkg::DATA_W+1];
      end else begin
         meta_reg <= pin_vec;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg[SYNC_W-1:ahr_pkg::DATA_W+1];
      end
   end
   assign {rst_s, cnv_s, rd_s, cs_n_s, wr_n_s, sel_s, data_s} = sync_reg;
   assign {rst_p, cnv_p, rd_p, cs_n_p, wr_n_p} = prev_reg;

   // reset, conversion and readout position
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      conv_cnt_next = conv_cnt_reg;
      busy_next = busy_reg;
      sample_next = sample_reg;
      result_next = result_reg;
      idx_next = idx_reg;
      bit_next = bit_reg;
      wr_data_next = wr_data_reg;
      wr_valid_next = 1'b0;
      full_next = 1'b0;
      part_next = 1'b0;
      if (rst_s) begin
         busy_next = 1'b0;
         if (~&rst_cnt_reg) begin
            rst_cnt_next = rst_cnt_reg + 1'b1;
         end
      end else begin
         rst_cnt_next = '0;
         if (rst_p) begin
            if (rst_cnt_reg >= FULL_MIN) begin
               full_next = 1'b1;
               sample_next = '0;
               result_next = '0;
               idx_next = '0;
               bit_next = '0;
            end else if (rst_cnt_reg >= PART_MIN) begin
               part_next = 1'b1;
               idx_next = '0;
               bit_next = '0;
            end
         end
         if (cnv_s && !cnv_p && !busy_reg) begin
            sample_next = i_channel_data;
            busy_next = 1'b1;
            conv_cnt_next = CONV_LAST;
         end else if (busy_reg) begin
            if (conv_cnt_reg == '0) begin
               busy_next = 1'b0;
               result_next = sample_reg;
               idx_next = '0;
               bit_next = '0;
            end else begin
               conv_cnt_next = conv_cnt_reg - 1'b1;
            end
         end
         if (!sel_s) begin
            if (!cs_n_s && rd_s && !rd_p) begin
               idx_next = idx_reg + 1'b1;
            end
            if (i_software_mode && !cs_n_s && wr_n_s && !wr_n_p) begin
               wr_valid_next = 1'b1;
               wr_data_next = data_s;
            end
         end else begin
            if (cs_n_p && !cs_n_s) begin
               bit_next = '0;
            end else if (!cs_n_s && !rd_s && rd_p && (~&bit_reg)) begin
               bit_next = bit_reg + 1'b1;
            end
         end
      end
   end

   // pin drive, data and marker
   always_comb begin
      logic [1:0] ll;
      logic [1:0] cpl_log;
      logic [ahr_pkg::CH_LOG-1:0] word_idx;
      logic [ahr_pkg::CH_LOG-1:0] ch;
      ll = ahr_pkg::lanes_log(i_software_mode, i_lane_opt);
      cpl_log = 2'(ahr_pkg::CH_LOG - int'(ll));
      word_idx = bit_reg[ahr_pkg::BIT_CNT_W-1:ahr_pkg::WORD_LSB];
      ch = '0;
      out_next = ahr_pkg::DATA_NONE;
      oe_next = ahr_pkg::DATA_NONE;
      marker_next = 1'b0;
      if (!rst_s && !cs_n_s) begin
         if (!sel_s) begin
            if (!rd_s) begin
               oe_next = ahr_pkg::DATA_ALL;
               out_next = result_reg[idx_reg];
            end
            marker_next = (idx_reg == '0) && !busy_reg;
         end else begin
            marker_next = (word_idx == '0);
            for (int l = 0; l < ahr_pkg::NUM_LANES; l++) begin
               if (l < (1 << ll)) begin
                  ch = ahr_pkg::CH_LOG'((l << cpl_log) + int'(word_idx));
                  oe_next[ahr_pkg::LANE_PIN[l]] = 1'b1;
                  if (int'(word_idx) < (1 << cpl_log)) begin
                     out_next[ahr_pkg::LANE_PIN[l]] =
                        result_reg[ch][~bit_reg[ahr_pkg::WORD_LSB-1:0]];
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rst_cnt_reg <= '0;
         conv_cnt_reg <= '0;
         busy_reg <= 1'b0;
         sample_reg <= '0;
         result_reg <= '0;
         idx_reg <= '0;
         bit_reg <= '0;
         wr_data_reg <= ahr_pkg::DATA_NONE;
         wr_valid_reg <= 1'b0;
         full_reg <= 1'b0;
         part_reg <= 1'b0;
         out_reg <= ahr_pkg::DATA_NONE;
         oe_reg <= ahr_pkg::DATA_NONE;
         marker_reg <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         conv_cnt_reg <= conv_cnt_next;
         busy_reg <= busy_next;
         sample_reg <= sample_next;
         result_reg <= result_next;
         idx_reg <= idx_next;
         bit_reg <= bit_next;
         wr_data_reg <= wr_data_next;
         wr_valid_reg <= wr_valid_next;
         full_reg <= full_next;
         part_reg <= part_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         marker_reg <= marker_next;
      end
   end

   assign link.busy = busy_reg;
   assign link.first_channel_marker = marker_reg;
   assign link.dev_data_out = out_reg;
   assign link.dev_data_oe = oe_reg;
   assign o_reg_wr_data = wr_data_reg;
   assign o_reg_wr_valid = wr_valid_reg;
   assign o_full_reset = full_reg;
   assign o_partial_reset = part_reg;
endmodule // ahr_device

// >>> rtl/ahr_host.sv
/*
 Host end of the readout link: reset pulses, conversion start, parallel
 and serial readout of all channels, parallel register writes. Assumes
 device pins are asynchronous; link clock made here by a divider.
*/
`timescale 1ns/10ps
module ahr_host (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // link to device
   ahr_link_if.host link,
   // command side
   input wire logic i_cmd_valid,
   input wire ahr_pkg::ahr_cmd_e i_cmd,
   input wire logic [ahr_pkg::DATA_W-1:0] i_wr_data,
   input wire logic i_serial_mode,
   input wire logic i_software_mode,
   input wire ahr_pkg::ahr_lanes_e i_lane_opt,
   output logic o_cmd_ready,
   // results
   output logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_first_seen,
   output logic o_busy
);
   localparam int CW = ahr_pkg::CNT_W;
   localparam int SW = 2 + ahr_pkg::DATA_W;
   localparam logic [CW-1:0] HALF_LAST = CW'(ahr_pkg::LINK_HALF_CYC - 1);
   localparam logic [CW-1:0] FULL_LAST = CW'(ahr_pkg::HOST_RST_FULL_CYC - 1);
   localparam logic [CW-1:0] PART_LAST =
      CW'(ahr_pkg::HOST_RST_PARTIAL_CYC - 1);
   localparam logic [CW-1:0] CNV_LAST = CW'(ahr_pkg::START_HIGH_CYC - 1);
   localparam logic [CW-1:0] WAIT_LAST = CW'(ahr_pkg::BUSY_WAIT_CYC - 1);

   typedef enum logic [3:0] {
      H_RESET, H_IDLE, H_CONV, H_WAIT_HI, H_WAIT_LO, H_PAR_LO, H_PAR_HI,
      H_SER_LEAD, H_SER_HI, H_SER_LO, H_WR_LO, H_WR_HI
   } ahr_hstate_e;

   logic [SW-1:0] meta_reg, sync_reg;
   logic busy_s, marker_s;
   logic [ahr_pkg::DATA_W-1:0] data_s;
   ahr_hstate_e state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [ahr_pkg::BIT_CNT_W-1:0] idx_reg, idx_next;
   logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] word_reg, word_next;
   logic rst_reg, rst_next, cnv_reg, cnv_next, rd_reg, rd_next;
   logic cs_n_reg, cs_n_next, wr_n_reg, wr_n_next, sel_reg, sel_next;
   logic [ahr_pkg::DATA_W-1:0] dout_reg, dout_next, doe_reg, doe_next;
   logic valid_reg, valid_next, first_reg, first_next;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= {link.busy, link.first_channel_marker, link.data_bus};
         sync_reg <= meta_reg;
      end
   end
   assign {busy_s, marker_s, data_s} = sync_reg;

   always_comb begin
      logic [1:0] ll;
      logic [1:0] cpl_log;
      logic [ahr_pkg::CH_LOG-1:0] ch;
      ll = ahr_pkg::lanes_log(i_software_mode, i_lane_opt);
      cpl_log = 2'(ahr_pkg::CH_LOG - int'(ll));
      ch = '0;
      state_next = state_reg;
      cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
      idx_next = idx_reg;
      word_next = word_reg;
      {rst_next, cnv_next, rd_next, cs_n_next, wr_n_next, sel_next} =
         {rst_reg, cnv_reg, rd_reg, cs_n_reg, wr_n_reg, sel_reg};
      dout_next = dout_reg;
      doe_next = doe_reg;
      valid_next = 1'b0;
      first_next = first_reg;
      unique case (state_reg)
         H_RESET: if (cnt_reg == '0) begin
            rst_next = 1'b0;
            state_next = H_IDLE;
         end
         H_IDLE: begin
            sel_next = i_serial_mode;
            if (i_cmd_valid) begin
               cnt_next = HALF_LAST;
               idx_next = '0;
               unique case (i_cmd)
                  ahr_pkg::AHR_CMD_CONVERT: begin
                     cnv_next = 1'b1;
                     cnt_next = CNV_LAST;
                     state_next = H_CONV;
                  end
                  ahr_pkg::AHR_CMD_READ: begin
                     cs_n_next = 1'b0;
                     rd_next = i_serial_mode;
                     first_next = 1'b0;
                     state_next = i_serial_mode ? H_SER_LEAD : H_PAR_LO;
                  end
                  ahr_pkg::AHR_CMD_WRITE: begin
                     if (!i_serial_mode && i_software_mode) begin
                        cs_n_next = 1'b0;
                        wr_n_next = 1'b0;
                        dout_next = i_wr_data;
                        doe_next = ahr_pkg::DATA_ALL;
                        state_next = H_WR_LO;
                     end
                  end
                  ahr_pkg::AHR_CMD_RESET_FULL: begin
                     rst_next = 1'b1;
                     cnt_next = FULL_LAST;
                     state_next = H_RESET;
                  end
                  default: begin
                     rst_next = 1'b1;
                     cnt_next = PART_LAST;
                     state_next = H_RESET;
                  end
               endcase
            end
         end
         H_CONV: if (cnt_reg == '0) begin
            cnv_next = 1'b0;
            cnt_next = WAIT_LAST;
            state_next = H_WAIT_HI;
         end
         H_WAIT_HI: if (busy_s) begin
            state_next = H_WAIT_LO;
         end else if (cnt_reg == '0) begin
            state_next = H_IDLE;
         end
         H_WAIT_LO: if (!busy_s) begin
            state_next = H_IDLE;
         end
         H_PAR_LO: if (cnt_reg == '0) begin
            word_next[idx_reg[ahr_pkg::CH_LOG-1:0]] = data_s;
            if (idx_reg == '0) begin
               first_next = marker_s;
            end
            rd_next = 1'b1;
            cnt_next = HALF_LAST;
            state_next = H_PAR_HI;
         end
         H_PAR_HI: if (cnt_reg == '0) begin
            if (idx_reg == ahr_pkg::BIT_CNT_W'(ahr_pkg::NUM_CH - 1)) begin
               cs_n_next = 1'b1;
               valid_next = 1'b1;
               state_next = H_IDLE;
            end else begin
               idx_next = idx_reg + 1'b1;
               rd_next = 1'b0;
               cnt_next = HALF_LAST;
               state_next = H_PAR_LO;
            end
         end
         H_SER_LEAD: if (cnt_reg == '0) begin
            cnt_next = HALF_LAST;
            state_next = H_SER_HI;
         end
         H_SER_HI: if (cnt_reg == '0) begin
            for (int l = 0; l < ahr_pkg::NUM_LANES; l++) begin
               if (l < (1 << ll)) begin
                  ch = ahr_pkg::CH_LOG'((l << cpl_log) +
                     int'(idx_reg[ahr_pkg::BIT_CNT_W-1:ahr_pkg::WORD_LSB]));
                  word_next[ch][~idx_reg[ahr_pkg::WORD_LSB-1:0]] =
                     data_s[ahr_pkg::LANE_PIN[l]];
               end
            end
            if (idx_reg == '0) begin
               first_next = marker_s;
            end
            if (idx_reg == ahr_pkg::BIT_CNT_W'((ahr_pkg::DATA_W << cpl_log)
                                                - 1)) begin
               cs_n_next = 1'b1;
               valid_next = 1'b1;
               state_next = H_IDLE;
            end else begin
               rd_next = 1'b0;
               cnt_next = HALF_LAST;
               state_next = H_SER_LO;
            end
         end
         H_SER_LO: if (cnt_reg == '0) begin
            rd_next = 1'b1;
            idx_next = idx_reg + 1'b1;
            cnt_next = HALF_LAST;
            state_next = H_SER_HI;
         end
         H_WR_LO: if (cnt_reg == '0) begin
            wr_n_next = 1'b1;
            cnt_next = HALF_LAST;
            state_next = H_WR_HI;
         end
         H_WR_HI: if (cnt_reg == '0) begin
            cs_n_next = 1'b1;
            doe_next = ahr_pkg::DATA_NONE;
            state_next = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= H_RESET;
         cnt_reg <= FULL_LAST;
         rst_reg <= 1'b1;
         {cnv_reg, rd_reg, cs_n_reg, wr_n_reg, sel_reg} <=
            ahr_pkg::PIN_IDLE[4:0];
         idx_reg <= '0;
         word_reg <= '0;
         dout_reg <= ahr_pkg::DATA_NONE;
         doe_reg <= ahr_pkg::DATA_NONE;
         valid_reg <= 1'b0;
         first_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         rst_reg <= rst_next;
         {cnv_reg, rd_reg, cs_n_reg, wr_n_reg, sel_reg} <=
            {cnv_next, rd_next, cs_n_next, wr_n_next, sel_next};
         idx_reg <= idx_next;
         word_reg <= word_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
         valid_reg <= valid_next;
         first_reg <= first_next;
      end
   end

   assign link.reset = rst_reg;
   assign link.conversion_start = cnv_reg;
   assign link.rd_sclk = rd_reg;
   assign link.cs_n = cs_n_reg;
   assign link.wr_n = wr_n_reg;
   assign link.interface_select = sel_reg;
   assign link.host_data_out = dout_reg;
   assign link.host_data_oe = doe_reg;
   assign o_cmd_ready = (state_reg == H_IDLE);
   assign o_rd_data = word_reg;
   assign o_rd_valid = valid_reg;
   assign o_first_seen = first_reg;
   assign o_busy = busy_s;
endmodule // ahr_host

// >>> sim/ahr_checker.sv
/* Pin checker for the device end of the readout link.
 Assumes the link pins share i_clk with both ends. */
`timescale 1ns/10ps
module ahr_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // link pins
   input wire logic reset,
   input wire logic conversion_start,
   input wire logic rd_sclk,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic interface_select,
   input wire logic busy,
   input wire logic first_channel_marker,
   input wire logic [ahr_pkg::DATA_W-1:0] dev_data_oe
);
   logic [11:0] busy_len_reg, busy_len_next;
   wire par_rd = !interface_select && !cs_n && !rd_sclk;
   wire par_off = !interface_select && (cs_n || rd_sclk);
   wire ser_rd = interface_select && !cs_n && !reset;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   always_comb begin
      busy_len_next = busy ? busy_len_reg + 12'h001 : 12'h000;
   end
   always_ff @(posedge i_clk) begin
      busy_len_reg <= i_srst ? 12'h000 : busy_len_next;
   end
   sequence start_s;
      $rose(conversion_start) && !busy && !reset && !$past(reset, 8);
   endsequence
   sequence read_open_s;
      $fell(cs_n) && wr_n && !busy && !reset;
   endsequence
   busy_rise_a: assert property (start_s |-> ##[1:5] busy)
      else $error("busy late");
   busy_len_a: assert property ($fell(busy) && !reset |->
      busy_len_reg >= ahr_pkg::CONV_CYC &&
      busy_len_reg <= ahr_pkg::CONV_CYC + 2) else $error("busy length");
   reset_quiet_a: assert property (reset [*6] |-> !busy &&
      !first_channel_marker && dev_data_oe == 16'h0000) else $error("reset");
   par_drive_a: assert property (par_rd [*5] |->
      dev_data_oe == 16'hFFFF) else $error("no parallel drive");
   par_release_a: assert property (par_off [*5] |->
      dev_data_oe == 16'h0000) else $error("parallel drive stuck");
   idle_release_a: assert property (cs_n [*6] |->
      dev_data_oe == 16'h0000 && !first_channel_marker) else $error("idle");
   serial_lanes_a: assert property (ser_rd [*5] |->
      dev_data_oe[8:7] == 2'h3 && dev_data_oe[2:0] == 3'h0)
      else $error("serial lanes");
   marker_start_a: assert property (read_open_s |->
      ##[2:6] first_channel_marker) else $error("marker missing");
endmodule // ahr_checker

// >>> sim/tb.sv
/* Bench: host and device ends joined by the link.
 Assumes the host gives its own power-up reset after i_srst. */
`timescale 1ns/10ps
module tb;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_cmd_valid = 1'b0;
   logic i_serial_mode = 1'b0;
   logic i_software_mode = 1'b0;
   ahr_pkg::ahr_lanes_e i_lane_opt = ahr_pkg::AHR_LANES_2;
   ahr_pkg::ahr_cmd_e i_cmd = ahr_pkg::AHR_CMD_CONVERT;
   logic [15:0] i_wr_data = 16'h3C5A;
   logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] i_channel_data = '0;
   logic [ahr_pkg::NUM_CH-1:0][ahr_pkg::DATA_W-1:0] o_rd_data;
   logic [15:0] o_reg_wr_data, reg_got, oe_seen, oe_exp;
   logic o_reg_wr_valid, o_full_reset, o_partial_reset, o_cmd_ready;
   logic o_rd_valid, o_first_seen, o_busy;
   // {serial, software, lane option, expected enables}
   logic [19:0] rows [6] = '{20'h0FFFF, 20'h80180, 20'hD0780, 20'hE07F8,
      20'hA0180, 20'h4FFFF};
   int mismatches = 0, n_tests = 0, n_full = 0, n_part = 0, n_wr = 0;
   int n_rd = 0, n0 = 0, n1 = 0;
   ahr_link_if link ();
   ahr_device ahr_device_inst (.i_clk, .i_srst, .link, .i_channel_data,
      .i_software_mode, .i_lane_opt, .o_reg_wr_data, .o_reg_wr_valid,
      .o_full_reset, .o_partial_reset);
   ahr_host ahr_host_inst (.i_clk, .i_srst, .link, .i_cmd_valid, .i_cmd,
      .i_wr_data, .i_serial_mode, .i_software_mode, .i_lane_opt,
      .o_cmd_ready, .o_rd_data, .o_rd_valid, .o_first_seen, .o_busy);
   ahr_checker ahr_checker_inst (.i_clk, .i_srst, .reset(link.reset),
      .conversion_start(link.conversion_start), .rd_sclk(link.rd_sclk),
      .cs_n(link.cs_n), .wr_n(link.wr_n), .busy(link.busy),
      .interface_select(link.interface_select),
      .first_channel_marker(link.first_channel_marker),
      .dev_data_oe(link.dev_data_oe));
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      n_full += o_full_reset;
      n_part += o_partial_reset;
      n_wr += o_reg_wr_valid;
      n_rd += o_rd_valid;
      oe_seen = oe_seen | link.dev_data_oe;
      if (o_reg_wr_valid) reg_got = o_reg_wr_data;
   end
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (o_cmd_ready !== 1'b1 && k < 5000) begin
         @(negedge i_clk);
         k++;
      end
      if (k == 5000) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic run(input ahr_pkg::ahr_cmd_e c);
      wait_ready();
      i_cmd = c;
      i_cmd_valid = 1'b1;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      @(negedge i_clk);
      wait_ready();
      repeat (8) @(negedge i_clk);
   endtask
   initial begin
      repeat (8) @(negedge i_clk);
      i_srst = 1'b0;
      wait_ready();
      repeat (8) @(negedge i_clk);
      check(n_full, 1);
      foreach (rows[r]) begin
         {i_serial_mode, i_software_mode} = rows[r][19:18];
         i_lane_opt = ahr_pkg::ahr_lanes_e'(rows[r][17:16]);
         oe_exp = rows[r][15:0];
         for (int c = 0; c < ahr_pkg::NUM_CH; c++) begin
            i_channel_data[c] = 16'h8421 + 16'(c) * 16'h1111 +
               16'(r) * 16'h0F07;
         end
         run(ahr_pkg::AHR_CMD_CONVERT);
         check(o_busy, 1'b0);
         oe_seen = 16'h0000;
         n0 = n_rd;
         run(ahr_pkg::AHR_CMD_READ);
         check(o_rd_data, i_channel_data);
         check({o_first_seen, oe_seen}, {1'b1, oe_exp});
         check(n_rd - n0, 1);
      end
      n0 = n_wr;
      run(ahr_pkg::AHR_CMD_WRITE);
      check(reg_got, 16'h3C5A);
      i_software_mode = 1'b0;
      i_wr_data = 16'hA5C3;
      run(ahr_pkg::AHR_CMD_WRITE);
      {i_serial_mode, i_software_mode} = 2'h3;
      run(ahr_pkg::AHR_CMD_WRITE);
      check({n_wr - n0, reg_got}, {32'h1, 16'h3C5A});
      n0 = n_part;
      n1 = n_full;
      run(ahr_pkg::AHR_CMD_RESET_PARTIAL);
      check({n_part - n0, n_full - n1}, {32'h1, 32'h0});
      run(ahr_pkg::AHR_CMD_RESET_FULL);
      check({n_part - n0, n_full - n1}, {32'h1, 32'h1});
      stop_test();
   end
endmodule // tb
